//--- rtl/adc_params.svh
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// Register offsets on the control bus.
`define ADC_OFS_FRAC_LO     8'h64
`define ADC_OFS_FRAC_HI     8'h65
`define ADC_OFS_FRAMES_LO   8'h67
`define ADC_OFS_FRAMES_MID  8'h68
`define ADC_OFS_FRAMES_HI   8'h69
`define ADC_OFS_RATE        8'h6a
`define ADC_OFS_FW_VER      8'h71
`define ADC_OFS_GO          8'h72
`define ADC_OFS_HSHELF_LO   8'h77
`define ADC_OFS_HSHELF_HI   8'h78
`define ADC_OFS_LSHELF_LO   8'h79
`define ADC_OFS_LSHELF_HI   8'h7a
`define ADC_OFS_HSHELF_GAIN 8'h7b
`define ADC_OFS_LSHELF_GAIN 8'h7c

// Reset values and the frame counter maximum.
`define ADC_SW_FRAC_LO      8'h46
`define ADC_SW_FRAC_HI      8'h5b
`define ADC_HW_FRAC_HI      8'h5b
`define ADC_RST_ZERO        8'h00
`define ADC_RST_FRAMES      24'h000000
`define ADC_FRAMES_MAX      24'hffffff

// Field positions and scale factors.
`define ADC_GO_BIT          0
`define ADC_FRAC_HI_WEIGHT  256
`define ADC_FRAC_SCALE      65536
`define ADC_GAIN_HALF_DB    3

// Seven-bit bus address of this device.
`define ADC_DEV_ADDR        7'h43

`endif

//--- rtl/adc_pkg.sv
package adc_pkg;

	typedef enum logic {ADC_IDLE, ADC_DECODE} adc_dec_e;

	typedef enum logic [2:0] {
		ADC_I_IDLE, ADC_I_ADDR, ADC_I_AACK, ADC_I_PTR,
		ADC_I_WACK, ADC_I_WDATA, ADC_I_RDATA, ADC_I_RACK
	} adc_i2c_e;

	typedef struct packed {
		logic        frame_done;
		logic        sync_ok;
		logic [15:0] frac;
		logic        rate_upd;
		logic [7:0]  rate_kbps;
		logic        boot_done;
	} adc_core_s;

	typedef struct packed {
		logic [4:0]  out_div;
		logic [15:0] frac;
		logic [24:0] vco_mult;
	} adc_pll_s;

	typedef struct packed {
		logic [15:0]        treble_hz;
		logic [15:0]        bass_hz;
		logic signed [9:0]  treble_half_db;
		logic signed [9:0]  bass_half_db;
	} adc_tone_s;

endpackage : adc_pkg

//--- rtl/adc_byte_reg.sv
`timescale 1ns/1ns
module adc_byte_reg #(
	parameter logic [7:0] HW_VAL  = 8'h00,
	parameter logic [7:0] SW_VAL  = 8'h00,
	parameter bit         HW_LOAD = 1'b1
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sw_rst_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       ld_i,
	input  wire logic [7:0] ld_data_i,
	output logic      [7:0] q_o
);

	// A register with HW_LOAD clear keeps whatever it held across a hardware reset.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i && HW_LOAD)
			q_o <= HW_VAL;
		else if (!rst_n_i)
			q_o <= q_o;
		else if (sw_rst_i)
			q_o <= SW_VAL;
		else if (ld_i)
			q_o <= ld_data_i;
		else if (wr_i)
			q_o <= wr_data_i;
	end

endmodule : adc_byte_reg

//--- rtl/adc_regs.sv
//Contract
//- Fraction is high byte times 256 plus low.
//- Output clock follows the fractional divider formula.
//- Soft reset loads 0x46/0x5B; sync loads fraction.
//- 24-bit read-only counter advances per decoded frame.
//- Both resets clear the frame counter.
//- Average bitrate byte in whole kilobits per second.
//- Firmware version readable after boot completes.
//- Go bit leaves idle; resets to zero.
//- Treble corner is a 16-bit hertz pair.
//- Bass corner is a 16-bit hertz pair.
//- Treble gain signed, 1.5 dB per unit.
//- Bass gain signed, 1.5 dB per unit.
//- Oscillator ticks divided by divider plus one.
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_regs #(
	// Arbitrary version code; a firmware build overrides it with its own.
	parameter logic [7:0] FW_VERSION = 8'h5a
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              sw_rst_i,
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe_o,
	input  wire adc_pkg::adc_core_s core_i,
	input  wire logic [7:0]        pll_n_i,
	input  wire logic [7:0]        pll_m_i,
	input  wire logic [4:0]        output_divider_value_i,
	input  wire logic              vco_tick_i,
	output logic                   ref_en_o,
	output logic                   oversampling_output_clock_o,
	output adc_pkg::adc_pll_s      pll_o,
	output adc_pkg::adc_tone_s     tone_o,
	output logic                   run_o,
	output adc_pkg::adc_dec_e      dec_state_o
);
	import adc_pkg::*;

	logic [7:0]  ptr, sh, wr_data, rd_data, ref_cnt;
	logic [2:0]  bcnt;
	logic        got_byte, rw, scl_q, sda_q, wr, ptr_step;
	adc_i2c_e    ist;
	logic [7:0]  frac_lo, frac_hi, go_reg, mean_rate;
	logic [7:0]  hs_lo, hs_hi, ls_lo, ls_hi, hs_gain, ls_gain;
	logic [23:0] frames;
	logic [4:0]  out_cnt;
	logic        scl_rise, scl_fall, start_c, stop_c, frame_inc, fw_valid;

	assign scl_rise  = scl_i & ~scl_q;
	assign scl_fall  = ~scl_i & scl_q;
	assign start_c   = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_c    = scl_i & scl_q & ~sda_q & sda_i;
	assign sda_o     = 1'b0;
	assign frame_inc = core_i.frame_done & (dec_state_o == ADC_DECODE);
	assign run_o     = go_reg[`ADC_GO_BIT];

	// Control bus: inputs are synchronous, so one sample is enough for edge detection.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	// Byte engine of the control bus slave. The pointer auto-increments per data byte.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || sw_rst_i) begin
			ist      <= ADC_I_IDLE;
			sh       <= 8'h00;
			bcnt     <= 3'h0;
			got_byte <= 1'b0;
			rw       <= 1'b0;
			ptr      <= 8'h00;
			sda_oe_o <= 1'b0;
			wr       <= 1'b0;
			wr_data  <= 8'h00;
			ptr_step <= 1'b0;
		end else begin
			wr <= 1'b0;
			if (start_c) begin
				ist      <= ADC_I_ADDR;
				bcnt     <= 3'h0;
				got_byte <= 1'b0;
				sda_oe_o <= 1'b0;
			end else if (stop_c) begin
				ist      <= ADC_I_IDLE;
				sda_oe_o <= 1'b0;
			end else if (scl_rise) begin
				unique case (ist)
					ADC_I_ADDR, ADC_I_PTR, ADC_I_WDATA: begin
						sh       <= {sh[6:0], sda_i};
						bcnt     <= bcnt + 3'h1;
						got_byte <= (bcnt == 3'h7);
					end
					ADC_I_RDATA: begin
						bcnt     <= bcnt + 3'h1;
						got_byte <= (bcnt == 3'h7);
					end
					ADC_I_RACK: begin
						if (sda_i)
							ist <= ADC_I_IDLE;
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				unique case (ist)
					ADC_I_ADDR: begin
						if (got_byte && sh[7:1] == `ADC_DEV_ADDR) begin
							rw       <= sh[0];
							ist      <= ADC_I_AACK;
							sda_oe_o <= 1'b1;
						end else if (got_byte) begin
							ist <= ADC_I_IDLE;
						end
						got_byte <= 1'b0;
					end
					ADC_I_AACK: begin
						bcnt <= 3'h0;
						if (rw) begin
							sh       <= rd_data;
							sda_oe_o <= ~rd_data[7];
							ist      <= ADC_I_RDATA;
						end else begin
							sda_oe_o <= 1'b0;
							ist      <= ADC_I_PTR;
						end
					end
					ADC_I_PTR, ADC_I_WDATA: begin
						if (got_byte) begin
							if (ist == ADC_I_PTR) begin
								ptr <= sh;
							end else begin
								wr      <= 1'b1;
								wr_data <= sh;
							end
							ptr_step <= (ist == ADC_I_WDATA);
							sda_oe_o <= 1'b1;
							ist      <= ADC_I_WACK;
						end
						got_byte <= 1'b0;
					end
					ADC_I_WACK: begin
						if (ptr_step)
							ptr <= ptr + 8'h01;
						sda_oe_o <= 1'b0;
						bcnt     <= 3'h0;
						ist      <= ADC_I_WDATA;
					end
					ADC_I_RDATA: begin
						if (got_byte) begin
							sda_oe_o <= 1'b0;
							ptr      <= ptr + 8'h01;
							ist      <= ADC_I_RACK;
						end else begin
							sh       <= {sh[6:0], 1'b0};
							sda_oe_o <= ~sh[6];
						end
						got_byte <= 1'b0;
					end
					ADC_I_RACK: begin
						sh       <= rd_data;
						sda_oe_o <= ~rd_data[7];
						bcnt     <= 3'h0;
						ist      <= ADC_I_RDATA;
					end
					ADC_I_IDLE: ;
				endcase
			end
		end
	end

	// Read side: unmapped offsets and write-only gaps read as zero.
	always_comb begin
		unique case (ptr)
			`ADC_OFS_FRAC_LO:     rd_data = frac_lo;
			`ADC_OFS_FRAC_HI:     rd_data = frac_hi;
			`ADC_OFS_FRAMES_LO:   rd_data = frames[7:0];
			`ADC_OFS_FRAMES_MID:  rd_data = frames[15:8];
			`ADC_OFS_FRAMES_HI:   rd_data = frames[23:16];
			`ADC_OFS_RATE:        rd_data = mean_rate;
			`ADC_OFS_FW_VER:      rd_data = fw_valid ? FW_VERSION : `ADC_RST_ZERO;
			`ADC_OFS_GO:          rd_data = go_reg;
			`ADC_OFS_HSHELF_LO:   rd_data = hs_lo;
			`ADC_OFS_HSHELF_HI:   rd_data = hs_hi;
			`ADC_OFS_LSHELF_LO:   rd_data = ls_lo;
			`ADC_OFS_LSHELF_HI:   rd_data = ls_hi;
			`ADC_OFS_HSHELF_GAIN: rd_data = hs_gain;
			`ADC_OFS_LSHELF_GAIN: rd_data = ls_gain;
			default:              rd_data = `ADC_RST_ZERO;
		endcase
	end

	// Low fraction byte is left untouched by hardware reset. A sync load from the
	// core wins over a host write in the same cycle.
	adc_byte_reg #(.HW_VAL(`ADC_RST_ZERO), .SW_VAL(`ADC_SW_FRAC_LO), .HW_LOAD(1'b0)) u_frac_lo (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_FRAC_LO), .wr_data_i(wr_data),
		.ld_i(core_i.sync_ok), .ld_data_i(core_i.frac[7:0]), .q_o(frac_lo));
	adc_byte_reg #(.HW_VAL(`ADC_HW_FRAC_HI), .SW_VAL(`ADC_SW_FRAC_HI)) u_frac_hi (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_FRAC_HI), .wr_data_i(wr_data),
		.ld_i(core_i.sync_ok), .ld_data_i(core_i.frac[15:8]), .q_o(frac_hi));
	adc_byte_reg u_go (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_GO), .wr_data_i({7'h00, wr_data[`ADC_GO_BIT]}),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(go_reg));
	adc_byte_reg u_hs_lo (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_HSHELF_LO), .wr_data_i(wr_data),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(hs_lo));
	adc_byte_reg u_hs_hi (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_HSHELF_HI), .wr_data_i(wr_data),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(hs_hi));
	adc_byte_reg u_ls_lo (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_LSHELF_LO), .wr_data_i(wr_data),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(ls_lo));
	adc_byte_reg u_ls_hi (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_LSHELF_HI), .wr_data_i(wr_data),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(ls_hi));
	adc_byte_reg u_hs_gain (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_HSHELF_GAIN), .wr_data_i(wr_data),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(hs_gain));
	adc_byte_reg u_ls_gain (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i),
		.wr_i(wr && ptr == `ADC_OFS_LSHELF_GAIN), .wr_data_i(wr_data),
		.ld_i(1'b0), .ld_data_i(8'h00), .q_o(ls_gain));

	// Frames are counted only while decoding; the counter rolls over silently.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || sw_rst_i)
			frames <= `ADC_RST_FRAMES;
		else if (frame_inc)
			frames <= frames + 24'h000001;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || sw_rst_i)
			mean_rate <= `ADC_RST_ZERO;
		else if (core_i.rate_upd)
			mean_rate <= core_i.rate_kbps;
	end

	// Boot status survives a soft reset: the firmware does not reload.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i)
			fw_valid <= 1'b0;
		else if (core_i.boot_done)
			fw_valid <= 1'b1;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || sw_rst_i)
			dec_state_o <= ADC_IDLE;
		else begin
			unique case (dec_state_o)
				ADC_IDLE:   if (run_o) dec_state_o <= ADC_DECODE;
				ADC_DECODE: if (!run_o) dec_state_o <= ADC_IDLE;
			endcase
		end
	end

	// Reference tick is the master clock divided by N+1.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ref_cnt  <= 8'h00;
			ref_en_o <= 1'b0;
		end else begin
			ref_en_o <= (ref_cnt == pll_n_i);
			ref_cnt  <= (ref_cnt == pll_n_i) ? 8'h00 : ref_cnt + 8'h01;
		end
	end

	// Output clock enable: one pulse per X+1 oscillator ticks.
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			out_cnt                     <= 5'h00;
			oversampling_output_clock_o <= 1'b0;
		end else begin
			oversampling_output_clock_o <= vco_tick_i && out_cnt == output_divider_value_i;
			if (vco_tick_i)
				out_cnt <= (out_cnt == output_divider_value_i) ? 5'h00 : out_cnt + 5'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pll_o  <= '0;
			tone_o <= '0;
		end else begin
			pll_o.out_div  <= output_divider_value_i;
			pll_o.frac     <= {frac_hi, frac_lo};
			pll_o.vco_mult <= {({1'b0, pll_m_i} + 9'h001), frac_hi, frac_lo};
			tone_o.treble_hz      <= {hs_hi, hs_lo};
			tone_o.bass_hz        <= {ls_hi, ls_lo};
			tone_o.treble_half_db <= 10'(`ADC_GAIN_HALF_DB * $signed({{2{hs_gain[7]}}, hs_gain}));
			tone_o.bass_half_db   <= 10'(`ADC_GAIN_HALF_DB * $signed({{2{ls_gain[7]}}, ls_gain}));
		end
	end

	property p_frac_value;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		!sw_rst_i |-> ##1 pll_o.frac == 16'(`ADC_FRAC_HI_WEIGHT * $past(frac_hi) + $past(frac_lo));
	endproperty
	a_frac_value: assert property (p_frac_value) else $error("fraction mismatch");
	property p_sw_frac;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		sw_rst_i ##1 !sw_rst_i |-> ##1 pll_o.frac == 16'h5b46;
	endproperty
	a_sw_frac: assert property (p_sw_frac) else $error("soft reset fraction wrong");
	property p_sync_frac;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(core_i.sync_ok && !sw_rst_i) |-> ##1 {frac_hi, frac_lo} == $past(core_i.frac);
	endproperty
	a_sync_frac: assert property (p_sync_frac) else $error("sync fraction not loaded");
	property p_frame_step;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(frame_inc && !sw_rst_i) |=> frames == 24'($past(frames) + 24'h000001);
	endproperty
	a_frame_step: assert property (p_frame_step) else $error("frame count step wrong");
	property p_frame_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!frame_inc && !sw_rst_i) |=> $stable(frames);
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame count moved");
	property p_frame_clr;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		sw_rst_i |=> frames == `ADC_RST_FRAMES;
	endproperty
	a_frame_clr: assert property (p_frame_clr) else $error("frame count not cleared");
	property p_frame_wrap;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(frames == `ADC_FRAMES_MAX && frame_inc) |=> frames == `ADC_RST_FRAMES;
	endproperty
	a_frame_wrap: assert property (p_frame_wrap) else $error("frame count did not wrap");
	property p_go_start;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr && ptr == `ADC_OFS_GO && wr_data[0] && !sw_rst_i) ##1 !sw_rst_i
			|-> ##1 dec_state_o == ADC_DECODE;
	endproperty
	a_go_start: assert property (p_go_start) else $error("decoder stayed idle");
	property p_treble_gain;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr && ptr == `ADC_OFS_HSHELF_GAIN && !sw_rst_i) ##1 !sw_rst_i
			|-> ##1 tone_o.treble_half_db == 10'($signed($past(wr_data, 2)) * 3);
	endproperty
	a_treble_gain: assert property (p_treble_gain) else $error("treble gain wrong");
	property p_bass_gain;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(wr && ptr == `ADC_OFS_LSHELF_GAIN && !sw_rst_i) ##1 !sw_rst_i
			|-> ##1 tone_o.bass_half_db == 10'($signed($past(wr_data, 2)) * 3);
	endproperty
	a_bass_gain: assert property (p_bass_gain) else $error("bass gain wrong");
endmodule : adc_regs

//--- verif/adc_host_model.sv
`timescale 1ns/1ns
`include "adc_params.svh"
module adc_host_model (
	input  wire logic clk_i,
	input  wire logic sda_line_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic [7:0] rbuf [0:7];
	logic       ack;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk_i);
	endtask : w
	// Also a repeated start: the data line is raised while the clock is low, then falls while the clock is high.
	task automatic sta();
		sda_o = 1'b1;
		w(2);
		scl_o = 1'b1;
		w(3);
		sda_o = 1'b0;
		w(3);
		scl_o = 1'b0;
		w(2);
	endtask : sta
	task automatic sto();
		sda_o = 1'b0;
		w(2);
		scl_o = 1'b1;
		w(3);
		sda_o = 1'b1;
		w(4);
	endtask : sto
	task automatic bit_x(input logic b, output logic s);
		sda_o = b;
		w(2);
		scl_o = 1'b1;
		w(2);
		s = sda_line_i;
		w(2);
		scl_o = 1'b0;
		w(2);
	endtask : bit_x
	task automatic snd(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask : snd
	task automatic wr(input logic [6:0] dev, input logic [7:0] p, input logic [63:0] d,
		input int n, output logic ok);
		sta();
		snd({dev, 1'b0});
		ok = ack;
		snd(p);
		for (int i = 0; i < n; i++) snd(d[8*i+:8]);
		sto();
	endtask : wr
	task automatic rd(input logic [7:0] p, input int n);
		logic s;
		sta();
		snd({`ADC_DEV_ADDR, 1'b0});
		snd(p);
		sta();
		snd({`ADC_DEV_ADDR, 1'b1});
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) bit_x(1'b1, rbuf[i][j]);
			bit_x(i == n - 1, s);
		end
		sto();
	endtask : rd
endmodule : adc_host_model

//--- verif/audio_decoder_ctrl_regs_test.sv
`timescale 1ns/1ns
module audio_decoder_ctrl_regs_test;
	import adc_pkg::*;
	// Arbitrary version code, chosen apart from the design default.
	localparam logic [7:0] FW = 8'h3c;
	logic        sys_clk, rst_n, sw_rst, scl, h_sda, sda_line, sda_o, sda_oe;
	logic        vco_tick, ref_en, oversampling_output_clock, run, ok, meas, rseen, oseen;
	logic [7:0]  pll_n, pll_m;
	logic [4:0]  xdiv;
	logic [15:0] th, bh;
	logic [7:0]  m [0:255];
	logic [31:0] seed;
	adc_core_s   core;
	adc_pll_s    pll;
	adc_tone_s   tone;
	adc_dec_e    dec;
	int          error_cnt, tests_run, cyc, fc, rcnt, tcnt, g;
	adc_regs #(.FW_VERSION(FW)) DUT (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .sw_rst_i(sw_rst),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .core_i(core),
		.pll_n_i(pll_n), .pll_m_i(pll_m), .output_divider_value_i(xdiv),
		.vco_tick_i(vco_tick), .ref_en_o(ref_en), .oversampling_output_clock_o(oversampling_output_clock),
		.pll_o(pll), .tone_o(tone), .run_o(run), .dec_state_o(dec));
	adc_host_model host (.clk_i(sys_clk), .sda_line_i(sda_line), .scl_o(scl), .sda_o(h_sda));
	assign sda_line = h_sda & (sda_oe ? sda_o : 1'b1);
	always #50 sys_clk = ~sys_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run
	// The run needs some 17000 cycles; over three times that means a hang.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end
	always @(negedge sys_clk) vco_tick <= meas & rnd() > 32'h7fffffff;
	always @(posedge sys_clk) begin
		if (!meas) begin
			rseen = 1'b0;
			oseen = 1'b0;
		end else begin
			if (ref_en) begin
				if (rseen) check(rcnt, pll_n + 1);
				rcnt = 1;
				rseen = 1'b1;
			end else rcnt++;
			if (oversampling_output_clock) begin
				if (oseen) check(tcnt, xdiv + 1);
				tcnt = vco_tick;
				oseen = 1'b1;
			end else tcnt += vco_tick;
		end
	end
	task automatic hw_rst();
		rst_n = 1'b0;
		repeat (6) @(negedge sys_clk);
		rst_n = 1'b1;
		foreach (m[i]) m[i] = 8'h00;
		m[8'h65] = 8'h5b;
		fc = 0;
		@(negedge sys_clk);
	endtask : hw_rst
	task automatic sw_pulse();
		sw_rst = 1'b1;
		@(negedge sys_clk);
		sw_rst = 1'b0;
		for (int a = 8'h67; a < 8'h7d; a++) if (a != 8'h71) m[a] = 8'h00;
		m[8'h64] = 8'h46;
		m[8'h65] = 8'h5b;
		fc = 0;
		repeat (3) @(negedge sys_clk);
	endtask : sw_pulse
	task automatic rd(input logic [7:0] p, input int n);
		host.rd(p, n);
		for (int i = 0; i < n; i++) check(host.rbuf[i], m[8'(p + i)]);
	endtask : rd
	task automatic wr(input logic [7:0] p, input logic [63:0] d, input int n);
		logic [7:0] a;
		host.wr(7'h43, p, d, n, ok);
		check(ok, 1'b1);
		for (int i = 0; i < n; i++) begin
			a = p + 8'(i);
			if (a inside {8'h64, 8'h65, [8'h77:8'h7c]}) m[a] = d[8*i+:8];
			if (a == 8'h72) m[a] = {7'h00, d[8*i]};
		end
		repeat (3) @(negedge sys_clk);
	endtask : wr
	task automatic chk_out();
		int tg, bg;
		tg = $signed(m[8'h7b]);
		bg = $signed(m[8'h7c]);
		check(pll.frac, {m[8'h65], m[8'h64]});
		check(pll.vco_mult, {9'(pll_m + 1), m[8'h65], m[8'h64]});
		check(pll.out_div, xdiv);
		check(tone.treble_hz, {m[8'h78], m[8'h77]});
		check(tone.bass_hz, {m[8'h7a], m[8'h79]});
		check(tone.treble_half_db, 10'(tg * 3));
		check(tone.bass_half_db, 10'(bg * 3));
	endtask : chk_out
	task automatic frames(input int k);
		repeat (k) begin
			core.frame_done = 1'b1;
			@(negedge sys_clk);
			core.frame_done = 1'b0;
			@(negedge sys_clk);
			if (m[8'h72][0]) fc++;
		end
		{m[8'h69], m[8'h68], m[8'h67]} = 24'(fc);
	endtask : frames
	initial begin
		sys_clk = 1'b0;
		// The low fraction byte powers up unknown; a soft reset held over the first
		// release gives it a defined value before anything looks at it.
		sw_rst = 1'b1;
		meas = 1'b0;
		vco_tick = 1'b0;
		seed = 32'd46;
		error_cnt = 0;
		tests_run = 0;
		cyc = 0;
		core = '0;
		pll_n = 8'h02;
		pll_m = 8'h07;
		xdiv = 5'h03;
		hw_rst();
		sw_rst = 1'b0;
		m[8'h64] = 8'h46;
		rd(8'h65, 6);
		rd(8'h71, 2);
		rd(8'h77, 6);
		check(pll.frac[15:8], 8'h5b);
		sw_pulse();
		rd(8'h64, 2);
		chk_out();
		repeat (3) begin
			pll_n = 8'(rnd() % 8);
			pll_m = 8'(rnd());
			xdiv = 5'(rnd());
			wr(8'h64, 64'(rnd()), 2);
			chk_out();
			meas = 1'b1;
			repeat (400) @(negedge sys_clk);
			meas = 1'b0;
		end
		core.frac = 16'(rnd());
		core.sync_ok = 1'b1;
		@(negedge sys_clk);
		core.sync_ok = 1'b0;
		{m[8'h65], m[8'h64]} = core.frac;
		rd(8'h64, 2);
		chk_out();
		core.rate_kbps = 8'(rnd());
		core.rate_upd = 1'b1;
		core.boot_done = 1'b1;
		@(negedge sys_clk);
		core.rate_upd = 1'b0;
		core.boot_done = 1'b0;
		m[8'h6a] = core.rate_kbps;
		m[8'h71] = FW;
		rd(8'h6a, 1);
		rd(8'h71, 1);
		wr(8'h7d, 64'h0c, 1);
		rd(8'h7d, 1);
		for (int i = 0; i < 4; i++) begin
			th = 16'(1000 + rnd() % 20000);
			bh = 16'(20 + rnd() % 731);
			g = (i == 0) ? 12 : (i == 1) ? -12 : int'(rnd() % 25) - 12;
			wr(8'h77, {16'h0000, 8'(-g), 8'(g), bh, th}, 6);
			chk_out();
			rd(8'h77, 6);
		end
		frames(3);
		wr(8'h67, 64'hffffff, 3);
		rd(8'h67, 3);
		wr(8'h72, 64'hff, 1);
		check(run, 1'b1);
		check(dec, ADC_DECODE);
		frames(300 + rnd() % 200);
		rd(8'h67, 3);
		sw_pulse();
		check(run, 1'b0);
		rd(8'h67, 6);
		rd(8'h71, 2);
		chk_out();
		wr(8'h72, 64'h01, 1);
		frames(5);
		rd(8'h67, 3);
		wr(8'h72, 64'h00, 1);
		check(dec, ADC_IDLE);
		frames(2);
		rd(8'h67, 3);
		hw_rst();
		rd(8'h67, 3);
		check(dec, ADC_IDLE);
		host.wr(7'h44, 8'h77, 64'h55, 1, ok);
		check(ok, 1'b0);
		rd(8'h77, 1);
		complete_run();
	end
endmodule : audio_decoder_ctrl_regs_test
